// ---- cpc_params.svh ----
// constants for the configuration pin control block
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH
`define CPC_MODE_W 4
`define CPC_MODE_RST 4'h0
`define CPC_MODE_ASYNC_PERIPH 4'h5
`define CPC_MODE_SLAVE_PAR 4'h7
`define CPC_MODE_PROC 4'hD
`define CPC_MODE_MASTER_PAR 4'hA
`define CPC_CLEAR_NS 2048
`define CPC_CLEAR_CYC ((`CPC_CLEAR_NS + 7) / 8)
`define CPC_BYTE_NS 64
`define CPC_BYTE_CYC ((`CPC_BYTE_NS + 7) / 8)
`define CPC_CNT_W 16
`define CPC_STATUS_BIT 7
`endif

// ---- cpc_pkg.sv ----
// types for the configuration pin control block
package cpc_pkg;
   typedef enum logic [5:0] {
      CPC_POWER = 6'h01,
      CPC_CLEAR = 6'h02,
      CPC_WAIT = 6'h04,
      CPC_LOAD = 6'h08,
      CPC_START = 6'h10,
      CPC_USER = 6'h20
   } cpc_state_type;
   typedef struct packed {
      logic chip_sel_low;
      logic chip_sel_high;
      logic rd_n;
      logic wr_n;
   } cpc_host_type;
   typedef struct packed {
      logic [2:0] program_restart_n;
      logic [2:0] init_in;
      logic [2:0] done_in;
      logic [2:0] power_ok;
      logic [2:0] scan_sel;
      logic [2:0] cs0;
      logic [2:0] cs1;
      logic [2:0] rd_n;
      logic [2:0] wr_n;
      logic [3:0] mode0;
      logic [3:0] mode1;
      cpc_state_type state;
      logic [15:0] cnt;
      logic [3:0] mode;
      logic init_drive;
      logic ready;
      logic mem_rd;
      logic done_rel;
      logic pins_rel;
      logic scan_en;
      logic status_oe;
      logic status_val;
   } cpc_state_all_type;
endpackage

// ---- cpc_ctrl.sv ----
// configuration pin control: mode latch, init handshake, select and status
// Summary of operation
// - latch mode pins on init rising edge
// - unselected boundary scan disabled after configuration
// - ready/busy shows room for another byte
// - selected read in async peripheral mode returns ready on status bit
// - master parallel drives memory read strobe
// - active-high in-progress output high until done
// - active-low in-progress output low until done
// - pull init low during power and clear
// - external low init holds wait state
// - selected when chip selects low and high
// - low read strobe makes status bit output
// - write strobe wins over simultaneous read
// - done release timed apart from pins
// - open-drain done high; external low delays
// - program input restarts and resets scan

`timescale 1ns/1ns
`include "cpc_params.svh"

module cpc_ctrl
(
   input wire logic mclk_i, // 125 MHz clock
   input wire logic reset_n_i, // synchronous reset, active low
   input wire logic power_ok_i, // supplies stable (pin)
   input wire logic program_restart_n_i, // restart request, active low (pin)
   input wire logic [3:0] mode_pins_i, // mode select pins
   input wire logic init_i, // init line level
   output logic init_o, // init drive value, always low
   output logic init_oe_o, // init pulled low while high
   input wire logic done_i, // done line level
   output logic done_o, // done drive value
   output logic done_oe_o, // done driven low while high
   input wire cpc_pkg::cpc_host_type host_i, // selects and strobes
   input wire logic byte_taken_i, // core consumed a byte
   input wire logic load_end_i, // last frame loaded
   input wire logic scan_sel_i, // boundary scan selected
   input wire logic [1:0] done_rel_opt_i, // done release delay in steps of 4 cycles
   input wire logic [1:0] pins_rel_opt_i, // pin release delay in steps of 4 cycles
   output logic status_data_bit_o, // status on data bit 7
   output logic status_data_bit_oe_o, // status bit driven
   output logic ready_busy_o, // ready high, busy low
   output logic mem_rd_o, // memory read strobe
   output logic cfg_active_high_o, // high while configuring
   output logic cfg_active_low_o, // low while configuring
   output logic wr_accept_o, // write strobe taken, one cycle
   output logic scan_en_o, // boundary scan enabled
   output logic pins_released_o, // config pins freed, user i/o live
   output logic [3:0] mode_o // latched mode
);
   import cpc_pkg::*;

   // one packed record holds every flop; nxt_r is its next value
   cpc_state_all_type r_ff;
   cpc_state_all_type nxt_r;

   // decode helpers, rebuilt every cycle from registered pins
   logic selected;
   logic init_rise;
   logic wr_edge;
   logic periph;

   // pins pass two flops before use; third stage only for edges
   always_comb
   begin
      nxt_r = r_ff;
      nxt_r.program_restart_n = {r_ff.program_restart_n[1:0], program_restart_n_i};
      nxt_r.init_in = {r_ff.init_in[1:0], init_i};
      nxt_r.done_in = {r_ff.done_in[1:0], done_i};
      nxt_r.power_ok = {r_ff.power_ok[1:0], power_ok_i};
      nxt_r.scan_sel = {r_ff.scan_sel[1:0], scan_sel_i};
      nxt_r.cs0 = {r_ff.cs0[1:0], host_i.chip_sel_low};
      nxt_r.cs1 = {r_ff.cs1[1:0], host_i.chip_sel_high};
      nxt_r.rd_n = {r_ff.rd_n[1:0], host_i.rd_n};
      nxt_r.wr_n = {r_ff.wr_n[1:0], host_i.wr_n};

      // mode pins get the same two-flop treatment as the strobes
      nxt_r.mode0 = mode_pins_i;
      nxt_r.mode1 = r_ff.mode0;

      // decodes read second and third stages only, never the first
      selected = !r_ff.cs0[1] && r_ff.cs1[1];
      init_rise = r_ff.init_in[1] && !r_ff.init_in[2];
      periph = (r_ff.mode == `CPC_MODE_ASYNC_PERIPH);
      wr_edge = 1'b0;

      // one shared down-counter; it parks at zero instead of wrapping
      nxt_r.cnt = (r_ff.cnt == 16'h0000) ? 16'h0000 : r_ff.cnt - 16'h0001;

      // mode captured only here, held otherwise
      if (init_rise && r_ff.state == CPC_WAIT)
         nxt_r.mode = r_ff.mode1;

      // configuration sequence
      case (r_ff.state)
         CPC_POWER:
         begin
            // hold init low until the supplies settle
            nxt_r.init_drive = 1'b1;
            if (r_ff.power_ok[1])
            begin
               nxt_r.state = CPC_CLEAR;
               nxt_r.cnt = 16'(`CPC_CLEAR_CYC);
            end
         end
         CPC_CLEAR:
         begin
            // memory clear time counted out with init still low
            nxt_r.init_drive = 1'b1;
            if (r_ff.cnt == 16'h0000)
            begin
               nxt_r.init_drive = 1'b0;
               nxt_r.state = CPC_WAIT;
            end
         end
         CPC_WAIT:
         begin
            // external low on init keeps us here
            if (init_rise)
            begin
               nxt_r.state = CPC_LOAD;
               nxt_r.ready = 1'b1;
            end
         end
         CPC_LOAD:
         begin
            // write beats read when both low
            wr_edge = selected && !r_ff.wr_n[1] && r_ff.wr_n[2];
            if (wr_edge && r_ff.ready)
            begin
               nxt_r.ready = 1'b0;
               nxt_r.cnt = 16'(`CPC_BYTE_CYC);
            end
            else if (!r_ff.ready && (byte_taken_i || r_ff.cnt == 16'h0000))
               nxt_r.ready = 1'b1;
            // strobe toggles every cycle; the memory paces itself on it
            nxt_r.mem_rd = (r_ff.mode == `CPC_MODE_MASTER_PAR) && !r_ff.mem_rd;
            if (load_end_i)
            begin
               nxt_r.state = CPC_START;
               nxt_r.mem_rd = 1'b0;
               nxt_r.cnt = 16'(done_rel_opt_i) << 2;
            end
         end
         CPC_START:
         begin
            // done and pins released on separate programmed delays
            if (r_ff.cnt == 16'h0000)
               nxt_r.done_rel = 1'b1;
            if (r_ff.done_rel && r_ff.done_in[1])
            begin
               nxt_r.state = CPC_USER;
               nxt_r.cnt = 16'(pins_rel_opt_i) << 2;
            end
         end
         CPC_USER:
         begin
            if (r_ff.cnt == 16'h0000)
               nxt_r.pins_rel = 1'b1;
         end
         default:
            nxt_r.state = CPC_POWER;
      endcase

      // unselected scan dies once configuration completes
      nxt_r.scan_en = !(r_ff.pins_rel && !r_ff.scan_sel[1]);
      nxt_r.status_oe = periph && selected && !r_ff.rd_n[1] && r_ff.wr_n[1]
                        && r_ff.state == CPC_LOAD;
      // status copy lags ready by a cycle; the host reads it asynchronously
      nxt_r.status_val = r_ff.ready;

      // restart wipes all control state except the latched mode, scan included
      if (!r_ff.program_restart_n[1])
      begin
         nxt_r.state = CPC_CLEAR;
         nxt_r.cnt = 16'(`CPC_CLEAR_CYC);
         nxt_r.init_drive = 1'b1;
         nxt_r.ready = 1'b0;
         nxt_r.mem_rd = 1'b0;
         nxt_r.done_rel = 1'b0;
         nxt_r.pins_rel = 1'b0;
         nxt_r.scan_en = 1'b0;
         nxt_r.status_oe = 1'b0;
      end

      // accept pulse only; writes while busy are dropped without notice
      wr_accept_o = wr_edge && r_ff.ready;
   end

   // single state register
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         r_ff <= '0;
         r_ff.program_restart_n <= 3'h7;
         r_ff.init_in <= 3'h0;
         r_ff.rd_n <= 3'h7;
         r_ff.wr_n <= 3'h7;
         r_ff.state <= CPC_POWER;
         r_ff.mode <= `CPC_MODE_RST;
         r_ff.init_drive <= 1'b1;
         r_ff.scan_en <= 1'b1;
      end
      else
         r_ff <= nxt_r;
   end

   // open-drain pins drive low only
   // the high level comes from the board pull-up
   assign init_o = 1'b0;
   assign init_oe_o = r_ff.init_drive;
   assign done_o = 1'b0;
   assign done_oe_o = !r_ff.done_rel;
   // status bit and its enable feed the data bit 7 pad
   assign status_data_bit_o = r_ff.status_val;
   assign status_data_bit_oe_o = r_ff.status_oe;
   assign ready_busy_o = r_ff.ready;
   assign mem_rd_o = r_ff.mem_rd;
   // both in-progress flags stay put until the pins are freed
   assign cfg_active_high_o = !r_ff.pins_rel;
   assign cfg_active_low_o = r_ff.pins_rel;
   assign scan_en_o = r_ff.scan_en;
   assign pins_released_o = r_ff.pins_rel;
   assign mode_o = r_ff.mode;
endmodule

// ---- cpc_host_model.sv ----
// far-side host: open-drain init and done lines with pull-ups
`timescale 1ns/1ns
module cpc_host_model
(
   input wire logic init_drv_i, // device drive value on init
   input wire logic init_oe_i, // device pulls init
   input wire logic done_drv_i, // device drive value on done
   input wire logic done_oe_i, // device pulls done
   input wire logic hold_init_i, // host holds init low
   input wire logic hold_done_i, // host holds done low
   output logic init_o, // init wire
   output logic done_o, // done wire
   output logic test_mode_sel_o // board strap on test mode select
);
   // pull-up wins only when nobody pulls low
   assign init_o = !hold_init_i && (init_oe_i ? init_drv_i : 1'b1);
   assign done_o = !hold_done_i && (done_oe_i ? done_drv_i : 1'b1);
   // board strap keeps test mode select high through configuration
   assign test_mode_sel_o = 1'b1;
endmodule

// ---- cpc_checker.sv ----
// assertions on the configuration pin control ports
`timescale 1ns/1ns
`include "cpc_params.svh"
module cpc_checker
(
   input wire logic mclk_i, // clock
   input wire logic reset_n_i, // reset
   input wire logic power_ok_i, // power good
   input wire logic program_restart_n_i, // restart
   input wire logic init_i, // init wire
   input wire logic init_oe_o, // init pull
   input wire logic done_i, // done wire
   input wire cpc_pkg::cpc_host_type host_i, // strobes
   input wire logic scan_sel_i, // scan select
   input wire logic ready_busy_o, // ready
   input wire logic status_data_bit_o, // status
   input wire logic status_data_bit_oe_o, // status drive
   input wire logic mem_rd_o, // memory strobe
   input wire logic cfg_active_high_o, // busy high
   input wire logic cfg_active_low_o, // busy low
   input wire logic wr_accept_o, // write taken
   input wire logic scan_en_o, // scan on
   input wire logic pins_released_o, // pins freed
   input wire logic [3:0] mode_o // mode
);
   import cpc_pkg::*;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   a_init_power: assert property ((!power_ok_i)[*6] |-> init_oe_o)
      else $error("init not pulled");
   a_active_high: assert property (cfg_active_high_o != pins_released_o
      && (done_i || cfg_active_high_o))
      else $error("high flag wrong");
   a_active_low: assert property (cfg_active_low_o == pins_released_o
      && (done_i || !cfg_active_low_o))
      else $error("low flag wrong");
   a_mode_latch: assert property ($changed(mode_o) |-> init_i)
      else $error("mode moved without init");
   a_write_busy: assert property (wr_accept_o |=> !ready_busy_o ##[1:9] ready_busy_o)
      else $error("busy window wrong");
   a_accept_sel: assert property (wr_accept_o |-> ready_busy_o && !$past(host_i.chip_sel_low, 2)
      && $past(host_i.chip_sel_high, 2))
      else $error("write taken unselected");
   a_status_ready: assert property (status_data_bit_oe_o && $stable(ready_busy_o)
      |-> status_data_bit_o == ready_busy_o)
      else $error("status bit wrong");
   a_write_wins: assert property ((!host_i.wr_n)[*6] |-> !status_data_bit_oe_o)
      else $error("status during write");
   a_mem_mode: assert property (mem_rd_o |-> mode_o == `CPC_MODE_MASTER_PAR)
      else $error("memory strobe in wrong mode");
   a_done_first: assert property ($rose(pins_released_o) |-> $past(done_i))
      else $error("pins freed while done low");
   a_scan_off: assert property ((pins_released_o && !scan_sel_i)[*6] |-> !scan_en_o)
      else $error("scan still on");
   a_restart: assert property ((!program_restart_n_i)[*6] |-> init_oe_o && !scan_en_o)
      else $error("restart ignored");
   c_write: cover property (wr_accept_o);
   c_release: cover property ($rose(pins_released_o));
   c_status: cover property (status_data_bit_oe_o);
endmodule
bind cpc_ctrl cpc_checker u_cpc_checker (.mclk_i, .reset_n_i, .power_ok_i, .program_restart_n_i,
   .init_i, .init_oe_o, .done_i, .host_i, .scan_sel_i, .ready_busy_o, .status_data_bit_o,
   .status_data_bit_oe_o, .mem_rd_o, .cfg_active_high_o, .cfg_active_low_o, .wr_accept_o,
   .scan_en_o, .pins_released_o, .mode_o);

// ---- testbench.sv ----
// self-checking bench for the configuration pin control block
`timescale 1ns/1ns
module testbench;
   import cpc_pkg::*;
   logic mclk_i = 0, reset_n_i = 0, power_ok_i = 0, prog_n = 1, hold_i = 1, hold_d = 0;
   logic load_end_i = 0, init_i, done_i, init_oe_o, done_oe_o, seen, st, st_oe, rdy, acc;
   logic mem_rd_o, act_hi, act_lo, scan_en_o, rel;
   logic init_drv, done_drv, tms, taken = 0, scan_sel = 0;
   logic [3:0] mode_pins_i = 4'h5, mode_o;
   cpc_host_type host_i = '{1'h0, 1'h1, 1'h1, 1'h1};
   int num_errors = 0, tests_run = 0, cycles = 0, i;
   cpc_ctrl u_cpc_ctrl (.mclk_i, .reset_n_i, .power_ok_i, .program_restart_n_i(prog_n),
      .mode_pins_i, .init_i, .init_o(init_drv), .init_oe_o, .done_i, .done_o(done_drv),
      .done_oe_o, .host_i,
      .byte_taken_i(taken), .load_end_i, .scan_sel_i(scan_sel), .done_rel_opt_i(2'h1),
      .pins_rel_opt_i(2'h2), .status_data_bit_o(st), .status_data_bit_oe_o(st_oe),
      .ready_busy_o(rdy), .mem_rd_o, .cfg_active_high_o(act_hi), .cfg_active_low_o(act_lo),
      .wr_accept_o(acc), .scan_en_o, .pins_released_o(rel), .mode_o);
   cpc_host_model u_cpc_host_model (.init_drv_i(init_drv), .init_oe_i(init_oe_o),
      .done_drv_i(done_drv), .done_oe_i(done_oe_o), .hold_init_i(hold_i),
      .hold_done_i(hold_d), .init_o(init_i), .done_o(done_i), .test_mode_sel_o(tms));
   always #4 mclk_i = ~mclk_i;
   // inputs move 1 ns after the edge so sampling never races
   task step(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task check(input string name, input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task end_of_test();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // whole run needs about 700 cycles
   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         end_of_test();
      end
   end
   task wait_init();
      for (i = 0; i < 400 && init_oe_o; i++)
         step(1);
   endtask
   task t_power();
      step(8);
      check("init_oe", init_oe_o, 4'h1);
      check("tms_high", tms, 4'h1);
      check("act_hi", act_hi, 4'h1);
      check("act_lo", act_lo, 4'h0);
      power_ok_i = 1;
      wait_init();
      check("clear_len", i > 250, 4'h1);
      step(20);
      check("mode_wait", mode_o, 4'h0);
      check("wait_busy", rdy, 4'h0);
      hold_i = 0;
      step(8);
      check("mode", mode_o, 4'h5);
      check("no_mem_rd", mem_rd_o, 4'h0);
      mode_pins_i = 4'hA;
      step(8);
      check("mode_kept", mode_o, 4'h5);
      $display("power test end");
   endtask
   task t_write();
      host_i.wr_n = 0;
      for (i = 0; i < 10 && !acc; i++)
         step(1);
      check("accept", acc, 4'h1);
      step(1);
      host_i.wr_n = 1;
      host_i.rd_n = 0;
      check("busy", rdy, 4'h0);
      step(5);
      check("st_busy", {st_oe, st}, 4'h2);
      host_i.wr_n = 0;
      step(6);
      check("wr_wins", st_oe, 4'h0);
      host_i.wr_n = 1;
      step(14);
      check("st_ready", {st_oe, st}, 4'h3);
      host_i = '{1'h0, 1'h0, 1'h1, 1'h0};
      seen = 0;
      for (i = 0; i < 8; i++)
      begin
         step(1);
         seen |= acc;
      end
      check("unselected", seen, 4'h0);
      host_i = '{1'h0, 1'h1, 1'h1, 1'h1};
      step(3);
      // second byte, released early by the core taking it
      host_i.wr_n = 0;
      step(4);
      check("busy2", rdy, 4'h0);
      taken = 1;
      step(1);
      taken = 0;
      check("taken", rdy, 4'h1);
      host_i.wr_n = 1;
      $display("write test end");
   endtask
   task t_done();
      hold_d = 1;
      load_end_i = 1;
      step(1);
      load_end_i = 0;
      step(30);
      check("done_free", done_oe_o, 4'h0);
      check("held", rel, 4'h0);
      hold_d = 0;
      for (i = 0; i < 40 && !rel; i++)
         step(1);
      check("pin_delay", {rel, i > 7}, 4'h3);
      check("flags", {act_hi, act_lo}, 4'h1);
      step(6);
      check("scan_off", scan_en_o, 4'h0);
      scan_sel = 1;
      step(4);
      check("scan_kept", scan_en_o, 4'h1);
      prog_n = 0;
      step(6);
      check("restart", {init_oe_o, scan_en_o}, 4'h2);
      prog_n = 1;
      wait_init();
      step(8);
      check("mode_new", mode_o, 4'hA);
      seen = 0;
      for (i = 0; i < 8; i++)
      begin
         step(1);
         seen |= mem_rd_o;
      end
      check("mem_rd", seen, 4'h1);
      host_i.rd_n = 0;
      step(5);
      check("no_status", st_oe, 4'h0);
      host_i.rd_n = 1;
      $display("done test end");
   endtask
   initial
   begin
      step(10);
      reset_n_i = 1;
      t_power();
      t_write();
      t_done();
      end_of_test();
   end
endmodule
